// ---- hw/fskmc_pkg.sv ----
// shared constants for the fsk modem configuration register block
package fskmc_pkg;
    // register width in both modes
    localparam int CFG_W = 48;
    localparam int CFG_NORM_W = 24;
    // value after reset, header 9B58h, frame length 08h in the upper word
    localparam logic [47:0] CFG_RESET = 48'h089B58_1362D7;
    // field positions
    localparam int F_FREQ_LO = 0;
    localparam int F_BAUD_LO = 3;
    localparam int F_DEV = 5;
    localparam int F_WDOG = 6;
    localparam int F_TOUT_LO = 7;
    localparam int F_DET_LO = 9;
    localparam int F_METH_LO = 12;
    localparam int F_MAINS = 14;
    localparam int F_MCLK_LO = 15;
    localparam int F_FREEZE = 17;
    localparam int F_HDR = 18;
    localparam int F_FLEN = 19;
    localparam int F_HLEN = 20;
    localparam int F_EXT = 21;
    localparam int F_HEADER_LO = 24;
    localparam int F_LENGTH_LO = 40;
    // detection method codes
    localparam logic [1:0] METH_PRE_RAW = 2'h0;
    localparam logic [1:0] METH_PRE_COND = 2'h1;
    localparam logic [1:0] METH_CAR_RAW = 2'h2;
    localparam logic [1:0] METH_CAR_COND = 2'h3;
    // time-out codes
    localparam logic [1:0] TOUT_OFF = 2'h0;
    localparam logic [1:0] TOUT_1S = 2'h1;
    localparam logic [1:0] TOUT_3S = 2'h2;
    // timing: clock rate and tick period
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 500;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    // times counted in 500 us ticks
    localparam int WDOG_MS = 1500;
    localparam int TOUT1_MS = 1000;
    localparam int TOUT3_MS = 3000;
    localparam logic [13:0] WDOG_TICKS = 14'(WDOG_MS * 1000 / TICK_US);
    localparam logic [13:0] TOUT1_TICKS = 14'(TOUT1_MS * 1000 / TICK_US);
    localparam logic [13:0] TOUT3_TICKS = 14'(TOUT3_MS * 1000 / TICK_US);
    // detection filter times in ticks: 500 us, 1 ms, 3 ms, 5 ms
    localparam logic [3:0] DET_T0 = 4'h1;
    localparam logic [3:0] DET_T1 = 4'h2;
    localparam logic [3:0] DET_T2 = 4'h6;
    localparam logic [3:0] DET_T3 = 4'hA;
    // bits in one frame word
    localparam int WORD_BITS = 16;
endpackage

// ---- hw/fskmc_top.sv ----
// configuration register of the fsk power-line modem and its decoded settings
`timescale 1ns/1ns
module fskmc_top #(
    parameter int TICK_CYC = fskmc_pkg::TICK_CYC // cycles per 500 us tick
) (
    input wire logic clk_in, // 250 MHz crystal domain clock
    input wire logic sys_rst_in, // async reset, active high
    input wire logic cfg_wr_in, // one-cycle load strobe from serial port
    input wire logic [47:0] cfg_wdata_in, // word to load
    input wire logic carrier_raw_in, // raw carrier present pin
    input wire logic preamble_raw_in, // raw preamble present pin
    input wire logic pll_lock_in, // demodulator pll locked pin
    input wire logic rx_clk_raw_in, // recovered bit clock pin
    input wire logic rx_data_raw_in, // demodulated data pin
    input wire logic host_mode_in, // host mode select pin, 1 = uart
    input wire logic tx_active_in, // transmitting pin level
    input wire logic wd_clear_n_in, // watchdog clear pulse, active low
    output logic [47:0] cfg_rdata_out, // register contents
    output logic [2:0] freq_sel_out, // carrier frequency code
    output logic [1:0] baud_sel_out, // baud rate code
    output logic dev_sel_out, // deviation select
    output logic mains_async_out, // 1 = asynchronous mains access
    output logic [1:0] mclk_sel_out, // master clock code
    output logic freeze_en_out, // output level freeze active
    output logic carrier_detect_n_out, // detection, active low
    output logic rx_tx_bit_clock_out, // gated receive bit clock
    output logic rx_data_out, // gated receive data
    output logic wd_reset_out, // one-cycle watchdog expiry pulse
    output logic tx_timeout_out // transmission blocked by time-out
);
    logic [47:0] cfg_q; // configuration register
    logic [47:0] cfg_d; // next register value
    logic [1:0] car_s_q, pre_s_q, pll_s_q, rck_s_q, rdt_s_q, mode_s_q, tx_s_q, wd_s_q;
    logic rck_d1_q; // delayed bit clock for edge find
    logic wd_d1_q; // delayed clear for edge find
    logic [31:0] div_q; // tick divider
    logic tick_q; // one-cycle 500 us enable
    logic det_raw; // selected raw detection
    logic det_q; // filtered detection
    logic [3:0] det_cnt_q; // filter ticks spent disagreeing
    logic [3:0] det_lim; // filter length in ticks
    logic [13:0] wd_cnt_q; // watchdog ticks
    logic [13:0] to_cnt_q; // transmit ticks
    logic [13:0] to_lim; // time-out limit
    logic ext, hdr_en, flen_en; // effective extended options
    logic [15:0] shf_q; // received bit history
    logic hit; // header seen on this bit
    logic hdr_pulse_q; // one bit period header notice
    logic [11:0] frm_cnt_q; // bits left in frame
    logic rck_rise; // recovered clock rising edge
    logic [1:0] meth; // detection method
    assign meth = cfg_q[fskmc_pkg::F_METH_LO+:2];
    assign ext = cfg_q[fskmc_pkg::F_EXT];
    // options act only while extended mode is on
    assign hdr_en = ext & cfg_q[fskmc_pkg::F_HDR];
    // length count needs header and extended
    assign flen_en = hdr_en & cfg_q[fskmc_pkg::F_FLEN];
    assign rck_rise = rck_s_q[1] & ~rck_d1_q;
    // next register value on a host load
    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr_in) begin
            // the low 24 bits always load
            cfg_d[23:0] = cfg_wdata_in[23:0];
            // upper bits load only when the new word enables extended mode
            if (cfg_wdata_in[fskmc_pkg::F_EXT]) begin
                cfg_d[47:24] = cfg_wdata_in[47:24];
            end
        end
    end
    // register storage, reset holds every documented default
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_q <= fskmc_pkg::CFG_RESET;
        end else begin
            // bit 11 is stored as written; host keeps it zero
            cfg_q <= cfg_d;
        end
    end
    // pin synchronisers, first stage read only by second
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            car_s_q <= 2'h0;
            pre_s_q <= 2'h0;
            pll_s_q <= 2'h0;
            rck_s_q <= 2'h0;
            rdt_s_q <= 2'h0;
            mode_s_q <= 2'h0;
            tx_s_q <= 2'h0;
            wd_s_q <= 2'h3;
            rck_d1_q <= 1'b0;
            wd_d1_q <= 1'b1;
        end else begin
            car_s_q <= {car_s_q[0], carrier_raw_in};
            pre_s_q <= {pre_s_q[0], preamble_raw_in};
            pll_s_q <= {pll_s_q[0], pll_lock_in};
            rck_s_q <= {rck_s_q[0], rx_clk_raw_in};
            rdt_s_q <= {rdt_s_q[0], rx_data_raw_in};
            mode_s_q <= {mode_s_q[0], host_mode_in};
            tx_s_q <= {tx_s_q[0], tx_active_in};
            wd_s_q <= {wd_s_q[0], wd_clear_n_in};
            rck_d1_q <= rck_s_q[1];
            wd_d1_q <= wd_s_q[1];
        end
    end
    // tick divider, all slow timers count these pulses
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            div_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (div_q == 32'(TICK_CYC - 1)) begin
            div_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 32'h1;
            tick_q <= 1'b0;
        end
    end
    // source of detection follows the method bits; preamble also needs pll lock
    assign det_raw = meth[1] ? car_s_q[1] : (pre_s_q[1] & pll_s_q[1]);
    always_comb begin
        case (cfg_q[fskmc_pkg::F_DET_LO+:2])
            2'h0: det_lim = fskmc_pkg::DET_T0;
            2'h1: det_lim = fskmc_pkg::DET_T1;
            2'h2: det_lim = fskmc_pkg::DET_T2;
            default: det_lim = fskmc_pkg::DET_T3;
        endcase
    end
    // filter: state changes only after disagreeing for the detection time
    // a glitch shorter than the time restarts the count, trading latency for noise
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            det_q <= 1'b0;
            det_cnt_q <= 4'h0;
        end else if (det_raw == det_q) begin
            det_cnt_q <= 4'h0;
        end else if (tick_q) begin
            if (det_cnt_q + 4'h1 >= det_lim) begin
                det_q <= det_raw;
                det_cnt_q <= 4'h0;
            end else begin
                det_cnt_q <= det_cnt_q + 4'h1;
            end
        end
    end
    // header match on the history plus the arriving bit, so the notice
    // comes on the last header bit, not one bit late; 8-bit mode takes either byte
    always_comb begin
        if (cfg_q[fskmc_pkg::F_HLEN]) begin
            hit = {shf_q[14:0], rdt_s_q[1]} == cfg_q[fskmc_pkg::F_HEADER_LO+:16];
        end else begin
            hit = ({shf_q[6:0], rdt_s_q[1]} == cfg_q[fskmc_pkg::F_HEADER_LO+8+:8])
                | ({shf_q[6:0], rdt_s_q[1]} == cfg_q[fskmc_pkg::F_HEADER_LO+:8]);
        end
    end
    // bit history and frame counter, advanced on each recovered clock rise
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shf_q <= 16'h0;
            hdr_pulse_q <= 1'b0;
            frm_cnt_q <= 12'h0;
        end else if (!hdr_en) begin
            shf_q <= 16'h0;
            hdr_pulse_q <= 1'b0;
            frm_cnt_q <= 12'h0;
        end else if (rck_rise) begin
            shf_q <= {shf_q[14:0], rdt_s_q[1]};
            // one clock period notice when length count is off
            hdr_pulse_q <= !flen_en && frm_cnt_q == 12'h0 && hit;
            if (frm_cnt_q != 12'h0) begin
                frm_cnt_q <= frm_cnt_q - 12'h1;
            end else if (flen_en && hit) begin
                // open a frame of length times 16 bits
                frm_cnt_q <= 12'(cfg_q[fskmc_pkg::F_LENGTH_LO+:8] * fskmc_pkg::WORD_BITS);
            end
        end
    end
    // carrier detect and receive gating
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            carrier_detect_n_out <= 1'b1;
            rx_tx_bit_clock_out <= 1'b0;
            rx_data_out <= 1'b0;
        end else begin
            // low while detected, or header notice in header mode
            carrier_detect_n_out <= hdr_en ? ~(hdr_pulse_q | (frm_cnt_q != 12'h0)) : ~det_q;
            if (flen_en && frm_cnt_q == 12'h0) begin
                // outside a counted frame clock is held, data parks at mode level
                rx_tx_bit_clock_out <= 1'b0;
                rx_data_out <= mode_s_q[1];
            end else if (!hdr_en && meth == fskmc_pkg::METH_PRE_COND
                         && !(det_q && pll_s_q[1])) begin
                rx_tx_bit_clock_out <= 1'b0;
                rx_data_out <= 1'b0;
            end else if (!hdr_en && meth == fskmc_pkg::METH_CAR_COND && !det_q) begin
                rx_tx_bit_clock_out <= 1'b0;
                rx_data_out <= mode_s_q[1];
            end else begin
                rx_tx_bit_clock_out <= rck_s_q[1];
                rx_data_out <= rdt_s_q[1];
            end
        end
    end
    // watchdog: a falling clear edge restarts it, expiry gives one pulse
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wd_cnt_q <= 14'h0;
            wd_reset_out <= 1'b0;
        end else begin
            wd_reset_out <= 1'b0;
            if (!cfg_q[fskmc_pkg::F_WDOG] || (wd_d1_q && !wd_s_q[1])) begin
                wd_cnt_q <= 14'h0;
            end else if (tick_q) begin
                if (wd_cnt_q + 14'h1 >= fskmc_pkg::WDOG_TICKS) begin
                    wd_cnt_q <= 14'h0;
                    wd_reset_out <= 1'b1;
                end else begin
                    wd_cnt_q <= wd_cnt_q + 14'h1;
                end
            end
        end
    end

    // time-out limit; code 3 is unused and treated as off
    assign to_lim = (cfg_q[fskmc_pkg::F_TOUT_LO+:2] == fskmc_pkg::TOUT_3S)
        ? fskmc_pkg::TOUT3_TICKS : fskmc_pkg::TOUT1_TICKS;
    // continuous transmission past the limit blocks; leaving transmit unlocks
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            to_cnt_q <= 14'h0;
            tx_timeout_out <= 1'b0;
        end else if (!tx_s_q[1]) begin
            to_cnt_q <= 14'h0;
            tx_timeout_out <= 1'b0;
        end else if (tick_q && !tx_timeout_out
                     && cfg_q[fskmc_pkg::F_TOUT_LO+:2] != fskmc_pkg::TOUT_OFF
                     && cfg_q[fskmc_pkg::F_TOUT_LO+:2] != 2'h3) begin
            if (to_cnt_q + 14'h1 >= to_lim) begin
                tx_timeout_out <= 1'b1;
            end else begin
                to_cnt_q <= to_cnt_q + 14'h1;
            end
        end
    end
    // decoded settings registered so every output leaves a flip-flop
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_rdata_out <= fskmc_pkg::CFG_RESET;
            freq_sel_out <= fskmc_pkg::CFG_RESET[fskmc_pkg::F_FREQ_LO+:3];
            baud_sel_out <= fskmc_pkg::CFG_RESET[fskmc_pkg::F_BAUD_LO+:2];
            dev_sel_out <= fskmc_pkg::CFG_RESET[fskmc_pkg::F_DEV];
            mains_async_out <= fskmc_pkg::CFG_RESET[fskmc_pkg::F_MAINS];
            mclk_sel_out <= fskmc_pkg::CFG_RESET[fskmc_pkg::F_MCLK_LO+:2];
            freeze_en_out <= 1'b0;
        end else begin
            cfg_rdata_out <= cfg_q;
            freq_sel_out <= cfg_q[fskmc_pkg::F_FREQ_LO+:3];
            baud_sel_out <= cfg_q[fskmc_pkg::F_BAUD_LO+:2];
            dev_sel_out <= cfg_q[fskmc_pkg::F_DEV];
            mains_async_out <= cfg_q[fskmc_pkg::F_MAINS];
            mclk_sel_out <= cfg_q[fskmc_pkg::F_MCLK_LO+:2];
            // freeze is active low in the field and needs extended mode
            freeze_en_out <= ext & ~cfg_q[fskmc_pkg::F_FREEZE];
        end
    end

    // checks on the block's own behaviour
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_low_load: assert property (cfg_wr_in |=> cfg_q[23:0] == $past(cfg_wdata_in[23:0]))
        else $error("low word not loaded");
    chk_upper_locked: assert property (cfg_wr_in && !cfg_wdata_in[21]
        |=> cfg_q[47:24] == $past(cfg_q[47:24]))
        else $error("upper word changed outside extended mode");
    chk_upper_load: assert property (cfg_wr_in && cfg_wdata_in[21]
        |=> cfg_q[47:24] == $past(cfg_wdata_in[47:24]))
        else $error("upper word not loaded in extended mode");
    chk_freq_decode: assert property (##1 freq_sel_out == $past(cfg_q[2:0]))
        else $error("frequency code mismatch");
    chk_freeze_gate: assert property (!ext |=> !freeze_en_out)
        else $error("freeze active outside extended mode");
    chk_pre_cond: assert property (meth == 2'h1 && !hdr_en && !det_q
        |=> !rx_tx_bit_clock_out && !rx_data_out)
        else $error("preamble gating failed");
    chk_car_cond: assert property (meth == 2'h3 && !hdr_en && !det_q
        |=> !rx_tx_bit_clock_out && rx_data_out == $past(mode_s_q[1]))
        else $error("carrier gating failed");
    chk_pass_through: assert property (!meth[0] && !hdr_en
        |=> rx_tx_bit_clock_out == $past(rck_s_q[1]))
        else $error("unconditioned clock not passed");
    chk_cd_level: assert property (!hdr_en |=> carrier_detect_n_out == !$past(det_q))
        else $error("carrier detect level wrong");
    chk_det_hold: assert property (det_raw != det_q && !tick_q |=> det_q == $past(det_q))
        else $error("filter changed without tick");
    chk_wd_off: assert property (!cfg_q[6] |=> !wd_reset_out)
        else $error("watchdog fired while disabled");
    chk_tout_off: assert property (cfg_q[8:7] == 2'h0 && !tx_timeout_out
        |=> !tx_timeout_out)
        else $error("time-out while disabled");
    chk_flen_gate: assert property (!hdr_en |=> frm_cnt_q == 12'h0)
        else $error("frame count without header mode");

    cov_ext_load: cover property (cfg_wr_in && cfg_wdata_in[21]);
    cov_det_on: cover property (!det_q ##1 det_q);
    cov_frame: cover property (frm_cnt_q == 12'h1 ##[1:1000] frm_cnt_q == 12'h0);
    cov_wd_fire: cover property (wd_reset_out);
endmodule

// ---- test/fskmc_host_model.sv ----
// host controller model that loads the configuration word over the port
`timescale 1ns/1ns
module fskmc_host_model (
    input wire logic clk_in, // crystal clock
    input wire logic sys_rst_in, // async reset, active high
    input wire logic req_in, // bench asks for one load
    input wire logic [47:0] word_in, // word the bench wants loaded
    input wire logic host_mode_in, // 1 = uart host mode
    output logic cfg_wr_out, // one-cycle load strobe
    output logic [47:0] cfg_wdata_out // word on the load port
);
    logic [47:0] safe_word; // word after host-side fixes
    // host-side cleanup of the word before it goes out
    always_comb begin
        safe_word = word_in;
        safe_word[11] = 1'b0;
        if (host_mode_in && !word_in[13]) begin
            safe_word[13] = 1'b1;
        end
    end
    // strobe for one cycle; between loads the data lines toggle between the last word and its inverse
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_wr_out <= 1'b0;
            cfg_wdata_out <= 48'h000000_000000;
        end else if (req_in) begin
            cfg_wr_out <= 1'b1;
            cfg_wdata_out <= safe_word;
        end else begin
            cfg_wr_out <= 1'b0;
            cfg_wdata_out <= ~cfg_wdata_out;
        end
    end
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the modem configuration register block
`timescale 1ns/1ns
module tb_top;
    logic clk_in = 1'b0; // 250 MHz clock
    logic sys_rst_in = 1'b1; // reset
    logic req = 1'b0; // load request to host model
    logic [47:0] word = 48'h000000_000000; // word to load
    logic cfg_wr; // load strobe
    logic [47:0] cfg_wdata; // load data
    logic carrier = 1'b0; // raw carrier pin
    logic preamble = 1'b0; // raw preamble pin
    logic pll = 1'b0; // pll lock pin
    logic rx_clk = 1'b0; // raw bit clock pin
    logic rx_data = 1'b0; // raw data pin
    logic host_mode = 1'b0; // host mode pin
    logic tx_act = 1'b0; // transmitting pin
    logic wd_clr_n = 1'b1; // watchdog clear pin
    logic [47:0] rdata; // register read-back
    logic [2:0] freq; // frequency code
    logic [1:0] baud; // baud code
    logic dev; // deviation
    logic mains; // mains access
    logic [1:0] mclk; // master clock code
    logic freeze; // freeze active
    logic cd_n; // carrier detect, active low
    logic bclk; // gated bit clock
    logic bdata; // gated data
    logic wd_rst; // watchdog pulse
    logic tout; // time-out level
    logic [47:0] cur = fskmc_pkg::CFG_RESET; // expected register contents
    int failures = 0; // mismatches
    int n_checks = 0; // comparisons
    int n; // measured cycles
    logic [47:0] wv; // word built for one load, not a design input
    localparam int TK = 10; // shortened tick so timers fit the run

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    fskmc_host_model fskmc_host_model_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .req_in(req), .word_in(word), .host_mode_in(host_mode),
        .cfg_wr_out(cfg_wr), .cfg_wdata_out(cfg_wdata));

    fskmc_top #(.TICK_CYC(TK)) fskmc_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .cfg_wr_in(cfg_wr), .cfg_wdata_in(cfg_wdata), .carrier_raw_in(carrier),
        .preamble_raw_in(preamble), .pll_lock_in(pll), .rx_clk_raw_in(rx_clk),
        .rx_data_raw_in(rx_data), .host_mode_in(host_mode), .tx_active_in(tx_act),
        .wd_clear_n_in(wd_clr_n), .cfg_rdata_out(rdata), .freq_sel_out(freq),
        .baud_sel_out(baud), .dev_sel_out(dev), .mains_async_out(mains),
        .mclk_sel_out(mclk), .freeze_en_out(freeze), .carrier_detect_n_out(cd_n),
        .rx_tx_bit_clock_out(bclk), .rx_data_out(bdata), .wd_reset_out(wd_rst),
        .tx_timeout_out(tout));

    // verdict and end of run
    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // compare one value, narrow ones zero-extended
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    // load a word through the host model; upper half only moves with bit 21 set
    task automatic wr_cfg(input logic [47:0] w);
        logic [47:0] v;
        v = w & ~48'h000000_000800;
        req <= 1'b1;
        word <= w;
        @(posedge clk_in);
        req <= 1'b0;
        cur = v[21] ? v : {cur[47:24], v[23:0]};
        cyc(5);
    endtask

    // read-back and all decoded field outputs against the expected contents
    task automatic chk_fields();
        chk("rdata", cur, rdata);
        chk("freq", 48'(cur[2:0]), 48'(freq));
        chk("baud", 48'(cur[4:3]), 48'(baud));
        chk("dev", 48'(cur[5]), 48'(dev));
        chk("mains", 48'(cur[14]), 48'(mains));
        chk("mclk", 48'(cur[16:15]), 48'(mclk));
        chk("freeze", 48'(cur[21] & ~cur[17]), 48'(freeze));
    endtask

    // bounded wait for an output level: 0 detect, 1 time-out, 2 watchdog pulse
    task automatic wait_sig(input int sel, input logic lvl, input int lim, output int cnt);
        logic s;
        cnt = 0;
        s = ~lvl;
        while (s !== lvl) begin
            @(posedge clk_in);
            #1;
            cnt++;
            s = (sel == 0) ? cd_n : (sel == 1) ? tout : wd_rst;
            if (cnt >= lim) begin
                failures++;
                $display("mismatch wait %0d expected %b seen %b", sel, lvl, s);
                tally_and_finish();
            end
        end
    endtask

    // gated receive outputs after the pins have settled through the syncs
    task automatic chk_rx(input logic c, input logic d);
        cyc(6);
        #1;
        chk("bit clock", 48'(c), 48'(bclk));
        chk("rx data", 48'(d), 48'(bdata));
    endtask

    // the k low bits of v on the receive pins, msb first, data set before each rise
    task automatic send_bits(input logic [15:0] v, input int k);
        for (int b = k - 1; b >= 0; b--) begin
            rx_data <= v[b];
            rx_clk <= 1'b0;
            cyc(4);
            rx_clk <= 1'b1;
            cyc(4);
        end
    endtask

    initial begin
        cyc(16);
        sys_rst_in <= 1'b0;
        cyc(2);
        chk_fields();
        chk("cd idle", 48'h1, 48'(cd_n));
        // every code of the freq, baud, dev, mains and mclk fields, upper half locked while bit 21 is low
        for (int i = 0; i < 8; i++) begin
            wv = 48'hA5A5A5_1362D7;
            wv[2:0] = 3'(i);
            wv[4:3] = 2'(i);
            wv[5] = i[0];
            wv[14] = i[1];
            wv[16:15] = ~2'(i);
            wv[11] = 1'b1;
            wr_cfg(wv);
            chk_fields();
        end
        wr_cfg(48'h123456_3162D7);
        chk_fields();
        wr_cfg(48'hFFFFFF_1162D7);
        chk_fields();
        // carrier raw, longest filter: not early, not late, same on drop
        wr_cfg(48'h000000_1366D7);
        carrier <= 1'b1;
        wait_sig(0, 1'b0, 200, n);
        chk("detect delay", 48'h1, 48'(n >= 9 * TK && n <= 10 * TK + 8));
        rx_clk <= 1'b1;
        rx_data <= 1'b1;
        chk_rx(1'b1, 1'b1);
        carrier <= 1'b0;
        wait_sig(0, 1'b1, 200, n);
        chk("drop delay", 48'h1, 48'(n >= 9 * TK && n <= 10 * TK + 8));
        chk_rx(1'b1, 1'b1);
        // conditioned carrier: clock low, data follows mode pin until detect
        wr_cfg(48'h000000_1376D7);
        host_mode <= 1'b1;
        rx_data <= 1'b0;
        chk_rx(1'b0, 1'b1);
        host_mode <= 1'b0;
        chk_rx(1'b0, 1'b0);
        carrier <= 1'b1;
        rx_data <= 1'b1;
        wait_sig(0, 1'b0, 200, n);
        chk_rx(1'b1, 1'b1);
        carrier <= 1'b0;
        wait_sig(0, 1'b1, 200, n);
        // conditioned preamble, shortest filter: gated until preamble and lock
        wr_cfg(48'h000000_1350D7);
        preamble <= 1'b1;
        chk_rx(1'b0, 1'b0);
        pll <= 1'b1;
        wait_sig(0, 1'b0, 40, n);
        chk("short filter", 48'h1, 48'(n <= TK + 8));
        chk_rx(1'b1, 1'b1);
        pll <= 1'b0;
        chk_rx(1'b0, 1'b0);
        preamble <= 1'b0;
        // transmit time-out, 1 s code
        wr_cfg(48'h000000_1362D7);
        tx_act <= 1'b1;
        wait_sig(1, 1'b1, 21000, n);
        chk("timeout 1s", 48'h1, 48'(n >= 1999 * TK && n <= 2000 * TK + 8));
        tx_act <= 1'b0;
        cyc(6);
        chk("timeout clear", 48'h0, 48'(tout));
        // watchdog expiry after 1.5 s without a clear pulse
        wd_clr_n <= 1'b0;
        cyc(3);
        wd_clr_n <= 1'b1;
        wait_sig(2, 1'b1, 31000, n);
        chk("watchdog", 48'h1, 48'(n >= 2998 * TK && n <= 3000 * TK + 8));
        @(posedge clk_in);
        #1;
        chk("wd pulse", 48'h0, 48'(wd_rst));
        // 16-bit header: notice not early, low for one bit period, clock passes
        wr_cfg(48'h089B58_3762D7);
        send_bits(16'h4DAC, 15);
        chk_rx(1'b1, 1'b0);
        chk("hdr early", 48'h1, 48'(cd_n));
        send_bits(16'h0000, 1);
        chk_rx(1'b1, 1'b0);
        chk("hdr hit", 48'h0, 48'(cd_n));
        send_bits(16'h0001, 1);
        chk_rx(1'b1, 1'b1);
        chk("hdr one bit", 48'h1, 48'(cd_n));
        // counted frame of one word: gated outside it, notice lasts 16 bits
        wr_cfg(48'h000000_1362D7);
        wr_cfg(48'h019B58_3F62D7);
        chk_rx(1'b0, 1'b0);
        send_bits(16'h9B58, 16);
        chk_rx(1'b1, 1'b0);
        chk("frame start", 48'h0, 48'(cd_n));
        send_bits(16'hFFFF, 15);
        chk_rx(1'b1, 1'b1);
        chk("frame body", 48'h0, 48'(cd_n));
        send_bits(16'h0001, 1);
        chk_rx(1'b0, 1'b0);
        chk("frame end", 48'h1, 48'(cd_n));
        // 8-bit header: the low byte alone gives the notice
        wr_cfg(48'h000000_1362D7);
        wr_cfg(48'h089B58_2762D7);
        send_bits(16'h0058, 8);
        chk_rx(1'b1, 1'b0);
        chk("byte hit", 48'h0, 48'(cd_n));
        // second reset in mid-run restores defaults
        sys_rst_in <= 1'b1;
        cyc(2);
        sys_rst_in <= 1'b0;
        cur = fskmc_pkg::CFG_RESET;
        cyc(2);
        chk_fields();
        tally_and_finish();
    end
endmodule
